// ---- core/tmrp_cnt_if.sv ----
// Purpose: control and count signals between the top and one counter
// Assumes: all signals on the core clock
// Notes: control side drives increments and writes, counter side answers
`timescale 1ns/1ps
interface tmrp_cnt_if;
  tmrp_pkg::tmrp_mode_t mode;
  logic inc_lo;
  logic inc_hi;
  logic wr_lo;
  logic wr_hi;
  logic [7:0] wdata;
  logic [7:0] lo;
  logic [7:0] hi;
  logic ovf_lo;
  logic ovf_hi;
  modport ctl (output mode, inc_lo, inc_hi, wr_lo, wr_hi, wdata,
               input lo, hi, ovf_lo, ovf_hi);
  modport cnt (input mode, inc_lo, inc_hi, wr_lo, wr_hi, wdata,
               output lo, hi, ovf_lo, ovf_hi);
endinterface : tmrp_cnt_if

// ---- core/tmrp_counter.sv ----
// Purpose: one timer's low and high count bytes in all four modes
// Assumes: increments are one-cycle strobes from the top
// Notes: a software write beats an increment in the same cycle
`timescale 1ns/1ps
module tmrp_counter (
  // clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // control and count
  tmrp_cnt_if.cnt bus
);

  logic [7:0] next_lo, next_hi;
  logic ovl, ovh;

  // next count per mode
  always_comb begin
    next_lo = bus.lo;
    next_hi = bus.hi;
    ovl = 1'b0;
    ovh = 1'b0;
    case (bus.mode)
      tmrp_pkg::MODE_13BIT: begin
        if (bus.inc_lo) begin
          next_lo[4:0] = bus.lo[4:0] + 5'h1; // 5-bit prescale
          if (bus.lo[4:0] == 5'h1f) begin
            next_hi = bus.hi + 8'h01;
            ovl = (bus.hi == 8'hff);
          end
        end
      end
      tmrp_pkg::MODE_16BIT: begin
        if (bus.inc_lo) begin
          {next_hi, next_lo} = {bus.hi, bus.lo} + 16'h0001;
          ovl = ({bus.hi, bus.lo} == 16'hffff);
        end
      end
      tmrp_pkg::MODE_RELOAD: begin
        if (bus.inc_lo) begin
          if (bus.lo == 8'hff) begin
            next_lo = bus.hi;
            ovl = 1'b1;
          end else next_lo = bus.lo + 8'h01;
          // high byte left as is, so every reload repeats
        end
      end
      tmrp_pkg::MODE_SPLIT: begin
        // two free 8-bit counters
        if (bus.inc_lo) begin
          next_lo = bus.lo + 8'h01;
          ovl = (bus.lo == 8'hff);
        end
        if (bus.inc_hi) begin
          next_hi = bus.hi + 8'h01;
          ovh = (bus.hi == 8'hff);
        end
      end
      default: next_lo = bus.lo;
    endcase
    if (bus.wr_lo) next_lo = bus.wdata;
    if (bus.wr_hi) next_hi = bus.wdata;
  end

  assign bus.ovf_lo = ovl;
  assign bus.ovf_hi = ovh;

  // count bytes
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      bus.lo <= tmrp_pkg::RST_REG;
      bus.hi <= tmrp_pkg::RST_REG;
    end else if (i_ce) begin
      bus.lo <= next_lo;
      bus.hi <= next_hi;
    end
  end

endmodule : tmrp_counter

// ---- core/tmrp_pkg.sv ----
// Purpose: shared constants and types of the timer and interrupt block
// Assumes: 8-bit special function register port, one core clock
// Notes: register addresses are byte addresses on the register port
package tmrp_pkg;

  // register addresses
  localparam logic [7:0] ADR_TIMER_CTRL = 8'h88;
  localparam logic [7:0] ADR_TIMER_MODE = 8'h89;
  localparam logic [7:0] ADR_T0_LOW = 8'h8a;
  localparam logic [7:0] ADR_T1_LOW = 8'h8b;
  localparam logic [7:0] ADR_T0_HIGH = 8'h8c;
  localparam logic [7:0] ADR_T1_HIGH = 8'h8d;
  localparam logic [7:0] ADR_CLOCK_CTRL = 8'h8e;
  localparam logic [7:0] ADR_IRQ_ENABLE = 8'ha8;
  localparam logic [7:0] ADR_IRQ_PRIO = 8'hb8;

  // timer_control_reg fields
  localparam int BIT_T1_OVF = 7;
  localparam int BIT_T1_RUN = 6;
  localparam int BIT_T0_OVF = 5;
  localparam int BIT_T0_RUN = 4;
  localparam int BIT_EXT1_REQ = 3;
  localparam int BIT_EXT1_EDGE = 2;
  localparam int BIT_EXT0_REQ = 1;
  localparam int BIT_EXT0_EDGE = 0;

  // timer_mode_reg fields, per timer nibble (timer 1 in the high nibble)
  localparam int BIT_GATE = 3;
  localparam int BIT_COUNTER_SEL = 2;
  localparam int T1_NIBBLE = 4;

  // clock control fields: time-base selects
  localparam int BIT_T1_TIMEBASE = 4;
  localparam int BIT_T0_TIMEBASE = 3;

  // interrupt enable and priority fields
  localparam int BIT_GLOBAL_EN = 7;
  localparam int N_PRIO_BITS = 6;

  // reset values and read-back constants
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] PRIO_READ_ONES = 8'h80;

  // time base dividers, in core clocks
  localparam logic [3:0] DIV_SLOW = 4'hc;
  localparam logic [1:0] DIV_FAST_LAST = 2'h3;

  // interrupt sources in fixed arbitration order
  localparam int N_SRC = 7;
  localparam logic [2:0] SRC_EXT0 = 3'h0;
  localparam logic [2:0] SRC_T0 = 3'h1;
  localparam logic [2:0] SRC_EXT1 = 3'h2;
  localparam logic [2:0] SRC_T1 = 3'h3;
  localparam logic [2:0] SRC_WDOG = 3'h6;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;
  localparam logic [15:0] VEC_WDOG = 16'h0063;

  // count modes as decoded from the two mode bits
  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD,
    MODE_SPLIT
  } tmrp_mode_t;

endpackage : tmrp_pkg

// ---- core/tmrp_top.sv ----
// Purpose: two timer/counters with prioritised vectored interrupts
// Assumes: pins are asynchronous; cpu strobes are on the core clock
// Notes: registers sit on a plain port, read data one cycle later
`timescale 1ns/1ps

module tmrp_top (
  // clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // pins
  input wire logic i_t0_count_input_pin,
  input wire logic i_t1_count_input_pin,
  input wire logic i_ext0_irq_pin,
  input wire logic i_ext1_irq_pin,
  // other interrupt sources, levels from neighbouring blocks
  input wire logic i_rx_done_flag,
  input wire logic i_tx_done_flag,
  input wire logic i_t2_overflow,
  input wire logic i_t2_external_flag,
  input wire logic i_watchdog_irq_flag,
  input wire logic i_watchdog_irq_on,
  // cpu handshake
  input wire logic i_vector_ack,
  input wire logic i_reti,
  output logic o_irq_req,
  output logic [15:0] o_irq_vector,
  // serial baud source
  output logic o_t1_baud_tick
);

  tmrp_cnt_if t0 ();
  tmrp_cnt_if t1 ();

  logic [2:0] sync_q [4];
  logic [3:0] pin_lvl, pin_prev, pin_fall, presc;
  logic tick_slow, tick_fast, t0_ovf, t0_run, t1_ovf, t1_run;
  logic ext0_req, ext0_edge, ext1_req, ext1_edge;
  logic [7:0] mode_reg, irq_en;
  logic [1:0] tb_sel;
  logic [5:0] irq_prio;
  logic t0_split, t1_frozen, t0_gate_ok, t1_gate_ok, t1_go;
  logic [6:0] pend, prio_vec, hi_cand, lo_cand;
  logic next_req, next_hi, sel_hi, take, ins_hi, ins_lo, sw_ctrl;
  logic [2:0] next_idx, sel_idx;

  // lowest set index, index 0 first in arbitration order
  function automatic logic [2:0] first_idx(input logic [6:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = tmrp_pkg::N_SRC - 1; i >= 0; i--) begin
      if (v[i]) r = 3'(i);
    end
    return r;
  endfunction : first_idx

  // vector address of a source
  function automatic logic [15:0] vec_of(input logic [2:0] idx);
    logic [15:0] v;
    v = tmrp_pkg::VEC_BASE + tmrp_pkg::VEC_STEP * {13'h0000, idx};
    if (idx == tmrp_pkg::SRC_WDOG) v = tmrp_pkg::VEC_WDOG;
    return v;
  endfunction : vec_of

  // selected time-base tick of one timer
  function automatic logic tb_tick(input logic fast, s, f);
    return fast ? f : s;
  endfunction : tb_tick

  // three-stage pin synchronisers; level moves only when the last two stages agree
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      for (int i = 0; i < 4; i++) sync_q[i] <= 3'h7;
      pin_lvl <= 4'hf;
      pin_prev <= 4'hf;
    end else if (i_ce) begin
      sync_q[0] <= {sync_q[0][1:0], i_t0_count_input_pin};
      sync_q[1] <= {sync_q[1][1:0], i_t1_count_input_pin};
      sync_q[2] <= {sync_q[2][1:0], i_ext0_irq_pin};
      sync_q[3] <= {sync_q[3][1:0], i_ext1_irq_pin};
      for (int i = 0; i < 4; i++) begin
        if (sync_q[i][1] == sync_q[i][2]) pin_lvl[i] <= sync_q[i][2];
      end
      pin_prev <= pin_lvl;
    end
  end

  assign pin_fall = pin_prev & ~pin_lvl;

  // shared prescaler: one tick per 12 clocks and one per 4
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      presc <= 4'h0;
    end else if (i_ce) begin
      if (presc == tmrp_pkg::DIV_SLOW - 4'h1) presc <= 4'h0;
      else presc <= presc + 4'h1;
    end
  end

  assign tick_slow = (presc == tmrp_pkg::DIV_SLOW - 4'h1);
  assign tick_fast = (presc[1:0] == tmrp_pkg::DIV_FAST_LAST);

  // mode decode and gating
  assign t0_split = (mode_reg[1:0] == 2'h3);
  assign t1_frozen = (mode_reg[5:4] == 2'h3);
  // gate needs the pin high as well as the run bit
  assign t0_gate_ok = ~mode_reg[tmrp_pkg::BIT_GATE] | pin_lvl[2];
  assign t1_gate_ok = ~mode_reg[tmrp_pkg::T1_NIBBLE + tmrp_pkg::BIT_GATE]
                      | pin_lvl[3];
  // with timer 0 split, timer 1 loses its run bit to the high byte
  assign t1_go = t0_split ? (~t1_frozen & t1_gate_ok)
                          : (t1_run & t1_gate_ok & ~t1_frozen);

  // timer 0 counter control
  assign t0.mode = tmrp_pkg::tmrp_mode_t'(mode_reg[1:0]);
  assign t0.inc_lo = t0_run & t0_gate_ok
    & (mode_reg[tmrp_pkg::BIT_COUNTER_SEL] ? pin_fall[0]
       : tb_tick(tb_sel[0], tick_slow, tick_fast));
  assign t0.inc_hi = t0_split & t1_run
    & tb_tick(tb_sel[0], tick_slow, tick_fast);
  assign t0.wr_lo = i_wr & (i_addr == tmrp_pkg::ADR_T0_LOW);
  assign t0.wr_hi = i_wr & (i_addr == tmrp_pkg::ADR_T0_HIGH);
  assign t0.wdata = i_wdata;

  // timer 1 counter control; frozen mode feeds no increments
  assign t1.mode = tmrp_pkg::tmrp_mode_t'(mode_reg[5:4]);
  assign t1.inc_lo = t1_go
    & (mode_reg[tmrp_pkg::T1_NIBBLE + tmrp_pkg::BIT_COUNTER_SEL]
       ? pin_fall[1] : tb_tick(tb_sel[1], tick_slow, tick_fast));
  assign t1.inc_hi = 1'b0;
  assign t1.wr_lo = i_wr & (i_addr == tmrp_pkg::ADR_T1_LOW);
  assign t1.wr_hi = i_wr & (i_addr == tmrp_pkg::ADR_T1_HIGH);
  assign t1.wdata = i_wdata;

  tmrp_counter u_t0 (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .bus(t0.cnt)
  );

  tmrp_counter u_t1 (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .bus(t1.cnt)
  );

  assign sw_ctrl = i_wr & (i_addr == tmrp_pkg::ADR_TIMER_CTRL);
  assign take = i_vector_ack & o_irq_req;

  // configuration registers written by software
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      mode_reg <= tmrp_pkg::RST_REG;
      tb_sel <= 2'h0;
      irq_en <= tmrp_pkg::RST_REG;
      irq_prio <= 6'h00;
      t0_run <= 1'b0;
      t1_run <= 1'b0;
      ext0_edge <= 1'b0;
      ext1_edge <= 1'b0;
    end else if (i_ce && i_wr) begin
      case (i_addr)
        tmrp_pkg::ADR_TIMER_MODE: mode_reg <= i_wdata;
        tmrp_pkg::ADR_CLOCK_CTRL: begin
          tb_sel <= {i_wdata[tmrp_pkg::BIT_T1_TIMEBASE],
                     i_wdata[tmrp_pkg::BIT_T0_TIMEBASE]};
        end
        tmrp_pkg::ADR_IRQ_ENABLE: irq_en <= i_wdata;
        tmrp_pkg::ADR_IRQ_PRIO: irq_prio <= i_wdata[5:0];
        tmrp_pkg::ADR_TIMER_CTRL: begin
          t0_run <= i_wdata[tmrp_pkg::BIT_T0_RUN];
          t1_run <= i_wdata[tmrp_pkg::BIT_T1_RUN];
          ext0_edge <= i_wdata[tmrp_pkg::BIT_EXT0_EDGE];
          ext1_edge <= i_wdata[tmrp_pkg::BIT_EXT1_EDGE];
        end
        default: mode_reg <= mode_reg;
      endcase
    end
  end

  // overflow flags: vector clear, then software, then hardware set wins
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      t0_ovf <= 1'b0;
      t1_ovf <= 1'b0;
    end else if (i_ce) begin
      if (take && sel_idx == tmrp_pkg::SRC_T0) t0_ovf <= 1'b0;
      if (take && sel_idx == tmrp_pkg::SRC_T1) t1_ovf <= 1'b0;
      if (sw_ctrl) begin
        t0_ovf <= i_wdata[tmrp_pkg::BIT_T0_OVF];
        t1_ovf <= i_wdata[tmrp_pkg::BIT_T1_OVF];
      end
      if (t0.ovf_lo) t0_ovf <= 1'b1;
      // split high byte takes timer 1's flag
      if (t0_split ? t0.ovf_hi : t1.ovf_lo) t1_ovf <= 1'b1;
    end
  end

  // external requests: edge mode latches falls, level mode tracks pin
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ext0_req <= 1'b0;
      ext1_req <= 1'b0;
    end else if (i_ce) begin
      if (!ext0_edge) ext0_req <= ~pin_lvl[2];
      else begin
        if (take && sel_idx == tmrp_pkg::SRC_EXT0) ext0_req <= 1'b0;
        if (sw_ctrl) ext0_req <= i_wdata[tmrp_pkg::BIT_EXT0_REQ];
        if (pin_fall[2]) ext0_req <= 1'b1;
      end
      if (!ext1_edge) ext1_req <= ~pin_lvl[3];
      else begin
        if (take && sel_idx == tmrp_pkg::SRC_EXT1) ext1_req <= 1'b0;
        if (sw_ctrl) ext1_req <= i_wdata[tmrp_pkg::BIT_EXT1_REQ];
        if (pin_fall[3]) ext1_req <= 1'b1;
      end
    end
  end

  // pending sources, all blocked by the global enable
  assign pend = {i_watchdog_irq_flag & i_watchdog_irq_on,
                 (i_t2_overflow | i_t2_external_flag) & irq_en[5],
                 (i_rx_done_flag | i_tx_done_flag) & irq_en[4],
                 t1_ovf & irq_en[3],
                 ext1_req & irq_en[2],
                 t0_ovf & irq_en[1],
                 ext0_req & irq_en[0]}
                & {tmrp_pkg::N_SRC{irq_en[tmrp_pkg::BIT_GLOBAL_EN]}};
  // watchdog has no priority bit and stays on the low level
  assign prio_vec = {1'b0, irq_prio};
  assign hi_cand = pend & prio_vec;
  assign lo_cand = pend & ~prio_vec;

  // arbitration: level first, then fixed order inside the level
  always_comb begin
    next_req = 1'b0;
    next_hi = 1'b0;
    next_idx = 3'h0;
    if (|hi_cand && !ins_hi) begin
      next_req = 1'b1;
      next_hi = 1'b1;
      next_idx = first_idx(hi_cand);
    end else if (|lo_cand && !ins_hi && !ins_lo) begin
      next_req = 1'b1;
      next_idx = first_idx(lo_cand);
    end
  end

  // request and vector; dropped for one cycle after each take
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_irq_req <= 1'b0;
      o_irq_vector <= tmrp_pkg::VEC_BASE;
      sel_idx <= 3'h0;
      sel_hi <= 1'b0;
    end else if (i_ce) begin
      o_irq_req <= next_req & ~take;
      o_irq_vector <= vec_of(next_idx);
      sel_idx <= next_idx;
      sel_hi <= next_hi;
    end
  end

  // in-service markers; a return ends the highest running level
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ins_hi <= 1'b0;
      ins_lo <= 1'b0;
    end else if (i_ce) begin
      if (i_reti) begin
        if (ins_hi) ins_hi <= 1'b0;
        else ins_lo <= 1'b0;
      end
      if (take) begin
        if (sel_hi) ins_hi <= 1'b1;
        else ins_lo <= 1'b1;
      end
    end
  end

  // baud source follows timer 1's own overflow in every mode
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_t1_baud_tick <= 1'b0;
    end else if (i_ce) begin
      o_t1_baud_tick <= t1.ovf_lo;
    end
  end

  // read data only in the cycle after a read strobe
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_rdata <= tmrp_pkg::RST_REG;
    end else if (i_ce) begin
      o_rdata <= tmrp_pkg::RST_REG;
      if (i_rd) begin
        case (i_addr)
          tmrp_pkg::ADR_TIMER_CTRL: begin
            o_rdata <= {t1_ovf, t1_run, t0_ovf, t0_run,
                        ext1_req, ext1_edge, ext0_req, ext0_edge};
          end
          tmrp_pkg::ADR_TIMER_MODE: o_rdata <= mode_reg;
          tmrp_pkg::ADR_T0_LOW: o_rdata <= t0.lo;
          tmrp_pkg::ADR_T1_LOW: o_rdata <= t1.lo;
          tmrp_pkg::ADR_T0_HIGH: o_rdata <= t0.hi;
          tmrp_pkg::ADR_T1_HIGH: o_rdata <= t1.hi;
          tmrp_pkg::ADR_CLOCK_CTRL: o_rdata <= {3'h0, tb_sel, 3'h0};
          tmrp_pkg::ADR_IRQ_ENABLE: o_rdata <= {irq_en[7], 1'b0, irq_en[5:0]};
          tmrp_pkg::ADR_IRQ_PRIO: begin
            o_rdata <= tmrp_pkg::PRIO_READ_ONES | {2'h0, irq_prio};
          end
          default: o_rdata <= tmrp_pkg::RST_REG;
        endcase
      end
    end
  end

endmodule : tmrp_top

// ---- dv/tb_top.sv ----
// Purpose: self-checking bench for the timer and interrupt block
// Assumes: clock enable tied high; cpu model answers requests
// Notes: fixed-seed random values with corner cases mixed in
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((e) !== (g)) begin \
  miscompares++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
  logic i_core_clk = 1'b0, i_srst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00;
  logic t0p = 1'b1, x0 = 1'b1, x1 = 1'b1, rx = 1'b0, tx = 1'b0;
  logic t2o = 1'b0, t2x = 1'b0, wdf = 1'b0, wdon = 1'b0;
  logic en = 1'b0, hold = 1'b0, s, ack, reti, o_irq_req, o_t1_baud_tick;
  logic [1:0] lat = 2'h0;
  logic [5:0] p;
  logic [6:0] m;
  logic [15:0] o_irq_vector, taken;
  logic [7:0] o_rdata, n_ack, d, q, r;
  int miscompares = 0, n_tests = 0, n_baud = 0, n, seed = 32'hc28c;
  // clock and baud pulse tally
  always #50 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) if (o_t1_baud_tick === 1'b1) n_baud++;
  tmrp_top tmrp_top_i (.i_core_clk, .i_srst, .i_ce(1'b1), .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_t0_count_input_pin(t0p),
    .i_t1_count_input_pin(1'b1), .i_ext0_irq_pin(x0),
    .i_ext1_irq_pin(x1), .i_rx_done_flag(rx), .i_tx_done_flag(tx),
    .i_t2_overflow(t2o), .i_t2_external_flag(t2x),
    .i_watchdog_irq_flag(wdf), .i_watchdog_irq_on(wdon),
    .i_vector_ack(ack), .i_reti(reti), .o_irq_req, .o_irq_vector,
    .o_t1_baud_tick);
  tmrp_cpu_model tmrp_cpu_model_i (.i_core_clk, .i_srst, .i_en(en),
    .i_hold(hold), .i_lat(lat), .i_irq_req(o_irq_req),
    .i_irq_vector(o_irq_vector), .o_vector_ack(ack), .o_reti(reti),
    .o_taken(taken), .o_n_ack(n_ack));
  // register port cycles: one-cycle strobes, read data the cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(negedge i_core_clk);
    v = o_rdata;
  endtask : rd
  task automatic cyc(input int k);
    repeat (k) @(posedge i_core_clk);
  endtask : cyc
  // polls the control byte; bounded so a dead timer cannot hang
  task automatic poll(input int b, output int k);
    k = 0;
    do begin
      rd(tmrp_pkg::ADR_TIMER_CTRL, d);
      k++;
    end while (d[b] !== 1'b1 && k < 40);
  endtask : poll
  task automatic pulse(input int k);
    repeat (k) begin
      t0p <= 1'b0;
      cyc(6);
      t0p <= 1'b1;
      cyc(6);
    end
  endtask : pulse
  // pending sources: bit index is the arbitration position
  task automatic drive(input logic [6:0] v);
    s = 1'($random(seed));
    x0 <= !v[0];
    x1 <= !v[2];
    rx <= v[4] & s;
    tx <= v[4] & !s;
    t2o <= v[5] & !s;
    t2x <= v[5] & s;
    wdf <= v[6];
  endtask : drive
  // winner: lowest position among high-level requests, else among all
  function automatic logic [15:0] exp_vec(input logic [6:0] v,
                                          input logic [5:0] pr);
    int w;
    w = -1;
    for (int k = 5; k >= 0; k--) if (v[k] && pr[k]) w = k;
    if (w < 0) for (int k = 6; k >= 0; k--) if (v[k]) w = k;
    if (w == 6) return tmrp_pkg::VEC_WDOG;
    return tmrp_pkg::VEC_BASE + tmrp_pkg::VEC_STEP * w[15:0];
  endfunction : exp_vec
  task automatic finish_test();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  initial begin
    cyc(20000);
    miscompares++;
    finish_test();
  end
  initial begin
    cyc(16);
    i_srst <= 1'b0;
    rd(tmrp_pkg::ADR_IRQ_PRIO, d);
    `CHK("ip_reset", 8'h80, d)
    rd(8'h00, d);
    `CHK("unmapped", 8'h00, d)
    // random enable and priority bytes read back
    repeat (8) begin
      r = 8'($random(seed));
      wr(tmrp_pkg::ADR_IRQ_ENABLE, r & 8'h7f);
      wr(tmrp_pkg::ADR_IRQ_PRIO, r);
      rd(tmrp_pkg::ADR_IRQ_ENABLE, d);
      `CHK("ie", r & 8'h3f, d)
      rd(tmrp_pkg::ADR_IRQ_PRIO, d);
      `CHK("ip", 8'h80 | r & 8'h3f, d)
    end
    // 16-bit roll-over on the fast base, then 13-bit on the slow one
    for (int f = 1; f >= 0; f--) begin
      wr(tmrp_pkg::ADR_TIMER_CTRL, 8'h00);
      wr(tmrp_pkg::ADR_TIMER_MODE, f ? 8'h01 : 8'h00);
      wr(tmrp_pkg::ADR_CLOCK_CTRL, f ? 8'h08 : 8'h00);
      wr(tmrp_pkg::ADR_T0_HIGH, 8'hff);
      wr(tmrp_pkg::ADR_T0_LOW, f ? 8'hfc : 8'h1c);
      wr(tmrp_pkg::ADR_TIMER_CTRL, 8'h10);
      poll(5, n);
      `CHK("rate", f ? n <= 12 : n >= 18 && n < 40, 1'b1)
      rd(tmrp_pkg::ADR_T0_HIGH, d);
      `CHK("wrap_high", 8'h00, d)
    end
    // auto-reload on timer 1 with its interrupt serviced
    r = {4'hf, 4'($random(seed))};
    wr(tmrp_pkg::ADR_TIMER_MODE, 8'h20);
    wr(tmrp_pkg::ADR_CLOCK_CTRL, 8'h10);
    wr(tmrp_pkg::ADR_T1_HIGH, r);
    wr(tmrp_pkg::ADR_T1_LOW, 8'hfe);
    wr(tmrp_pkg::ADR_IRQ_ENABLE, 8'h88);
    lat <= 2'($random(seed));
    en <= 1'b1;
    wr(tmrp_pkg::ADR_TIMER_CTRL, 8'h40);
    cyc(60);
    wr(tmrp_pkg::ADR_TIMER_CTRL, 8'h00);
    rd(tmrp_pkg::ADR_T1_HIGH, d);
    `CHK("reload_kept", r, d)
    rd(tmrp_pkg::ADR_T1_LOW, q);
    `CHK("reloaded", q >= r, 1'b1)
    `CHK("t1_vector", 16'h001b, taken)
    `CHK("baud", n_baud > 0, 1'b1)
    cyc(20);
    rd(tmrp_pkg::ADR_T1_LOW, d);
    `CHK("stopped", q, d)
    // falling pin edges counted only while the gate pin is high
    en <= 1'b0;
    wr(tmrp_pkg::ADR_IRQ_ENABLE, 8'h00);
    wr(tmrp_pkg::ADR_TIMER_MODE, 8'h0d);
    wr(tmrp_pkg::ADR_T0_LOW, 8'h00);
    x0 <= 1'b0;
    wr(tmrp_pkg::ADR_TIMER_CTRL, 8'h10);
    n = 1 + $unsigned($random(seed)) % 8;
    for (int g = 0; g < 2; g++) begin
      pulse(n);
      rd(tmrp_pkg::ADR_T0_LOW, d);
      `CHK("pin_count", g ? n[7:0] : 8'h00, d)
      @(posedge i_core_clk) x0 <= 1'b1;
      cyc(6);
    end
    // split timer 0 while timer 1 is frozen
    wr(tmrp_pkg::ADR_TIMER_MODE, 8'h33);
    wr(tmrp_pkg::ADR_CLOCK_CTRL, 8'h18);
    wr(tmrp_pkg::ADR_T1_LOW, 8'h5a);
    wr(tmrp_pkg::ADR_T0_HIGH, 8'hfc);
    wr(tmrp_pkg::ADR_TIMER_CTRL, 8'h50);
    cyc(40);
    rd(tmrp_pkg::ADR_T1_LOW, d);
    `CHK("t1_frozen", 8'h5a, d)
    rd(tmrp_pkg::ADR_TIMER_CTRL, d);
    `CHK("split_high_flag", 1'b1, d[7])
    // arbitration; first pass has the global enable off
    wr(tmrp_pkg::ADR_TIMER_CTRL, 8'h00);
    wdon <= 1'b1;
    for (int t = 0; t < 14; t++) begin
      m = (t < 2) ? 7'h75 : 7'($random(seed)) & 7'h75;
      p = (t < 2) ? 6'h00 : 6'($random(seed));
      wr(tmrp_pkg::ADR_IRQ_ENABLE, t == 0 ? 8'h3f : 8'hbf);
      wr(tmrp_pkg::ADR_IRQ_PRIO, {2'b00, p});
      drive(m);
      cyc(10);
      @(negedge i_core_clk);
      `CHK("req", t != 0 && m != 0, o_irq_req)
      if (t != 0 && m != 0)
        `CHK("vector", exp_vec(m, p), o_irq_vector)
    end
    // high level in service holds back every other request
    drive(7'h75);
    q = n_ack;
    wr(tmrp_pkg::ADR_IRQ_PRIO, 8'h01);
    cyc(8);
    hold <= 1'b1;
    en <= 1'b1;
    cyc(30);
    `CHK("nest_vector", 16'h0003, taken)
    `CHK("nest_count", q + 8'h01, n_ack)
    hold <= 1'b0;
    drive(7'h00);
    cyc(60);
    finish_test();
  end
endmodule : tb_top

// ---- dv/tmrp_checker.sv ----
// Purpose: port-level checks of the timer and interrupt block
// Assumes: clock enable held high by the bench
// Notes: shadows enable, priority and in-service state seen at the ports
`timescale 1ns/1ps
module tmrp_checker (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // handshake and baud
  input wire logic i_vector_ack,
  input wire logic i_reti,
  input wire logic o_irq_req,
  input wire logic [15:0] o_irq_vector,
  input wire logic o_t1_baud_tick
);
  logic [7:0] ie_q;
  logic [7:0] ie_d;
  logic [7:0] ip_q;
  logic hi_svc;
  logic lo_svc;
  logic wd;
  logic [2:0] idx;
  // source index from the vector; watchdog has no enable or priority bit
  assign idx = o_irq_vector[5:3];
  assign wd = o_irq_vector == tmrp_pkg::VEC_WDOG;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  // shadow bytes; one stale cycle kept since a request is registered
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ie_q <= 8'h00;
      ie_d <= 8'h00;
      ip_q <= 8'h00;
    end else if (i_ce) begin
      ie_d <= ie_q;
      if (i_wr && i_addr == tmrp_pkg::ADR_IRQ_ENABLE) ie_q <= i_wdata;
      if (i_wr && i_addr == tmrp_pkg::ADR_IRQ_PRIO) ip_q <= i_wdata;
    end
  end
  // in-service levels; return applied before a same-edge ack
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      hi_svc <= 1'b0;
      lo_svc <= 1'b0;
    end else if (i_ce) begin
      if (i_reti && hi_svc) hi_svc <= 1'b0;
      if (i_reti && !hi_svc) lo_svc <= 1'b0;
      if (i_vector_ack && o_irq_req) begin
        if (!wd && ip_q[idx]) hi_svc <= 1'b1;
        else lo_svc <= 1'b1;
      end
    end
  end
  property p_ie_rd;
    i_rd && i_addr == tmrp_pkg::ADR_IRQ_ENABLE |=>
      o_rdata == {ie_q[7], 1'b0, ie_q[5:0]};
  endproperty
  a_ie_rd: assert property (p_ie_rd) else $error("enable read-back");
  property p_ip_rd;
    i_rd && i_addr == tmrp_pkg::ADR_IRQ_PRIO |=>
      o_rdata == {2'b10, ip_q[5:0]};
  endproperty
  a_ip_rd: assert property (p_ip_rd) else $error("prio read-back");
  property p_global;
    o_irq_req |-> ie_q[7] || ie_d[7];
  endproperty
  a_global: assert property (p_global) else $error("req, global off");
  property p_source_en;
    o_irq_req && !wd |-> ie_q[idx] || ie_d[idx];
  endproperty
  a_source_en: assert property (p_source_en) else $error("req, src off");
  property p_ack_drop;
    i_vector_ack && o_irq_req |=> !o_irq_req;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("req held");
  property p_high_svc;
    hi_svc |-> !o_irq_req;
  endproperty
  a_high_svc: assert property (p_high_svc) else $error("high nested");
  property p_low_svc;
    lo_svc && o_irq_req |-> !wd && ip_q[idx];
  endproperty
  a_low_svc: assert property (p_low_svc) else $error("low nested");
  property p_vector;
    o_irq_req |-> o_irq_vector inside {16'h0003, 16'h000b, 16'h0013,
      16'h001b, 16'h0023, 16'h002b, 16'h0063};
  endproperty
  a_vector: assert property (p_vector) else $error("bad vector");
  property p_baud;
    $rose(o_t1_baud_tick) |=> !o_t1_baud_tick;
  endproperty
  a_baud: assert property (p_baud) else $error("baud tick long");
  c_high: cover property (hi_svc);
  c_low: cover property (lo_svc);
  c_baud: cover property (o_t1_baud_tick);
endmodule : tmrp_checker
bind tmrp_top tmrp_checker tmrp_checker_i (.i_core_clk, .i_srst, .i_ce,
  .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_vector_ack, .i_reti,
  .o_irq_req, .o_irq_vector, .o_t1_baud_tick);

// ---- dv/tmrp_cpu_model.sv ----
// Purpose: cpu side of the interrupt handshake
// Assumes: one ack pulse per taken request, returns in stack order
// Notes: latency input gives prompt or slow answers; hold delays returns
`timescale 1ns/1ps
module tmrp_cpu_model (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // behaviour controls
  input wire logic i_en,
  input wire logic i_hold,
  input wire logic [1:0] i_lat,
  // handshake
  input wire logic i_irq_req,
  input wire logic [15:0] i_irq_vector,
  output logic o_vector_ack,
  output logic o_reti,
  // record of taken requests
  output logic [15:0] o_taken,
  output logic [7:0] o_n_ack
);
  logic [1:0] wait_cnt;
  logic [2:0] depth;
  // gap after every pulse so one request is never taken twice
  always @(posedge i_core_clk) begin
    o_vector_ack <= 1'b0;
    o_reti <= 1'b0;
    if (i_srst) begin
      wait_cnt <= 2'h0;
      depth <= 3'h0;
      o_taken <= 16'h0000;
      o_n_ack <= 8'h00;
    end else if (o_vector_ack || o_reti) begin
      wait_cnt <= 2'h0;
      if (o_vector_ack && i_irq_req) begin
        o_taken <= i_irq_vector;
        o_n_ack <= o_n_ack + 8'h01;
        depth <= depth + 3'h1;
      end
    end else if (i_en && i_irq_req) begin
      if (wait_cnt == i_lat) o_vector_ack <= 1'b1;
      else wait_cnt <= wait_cnt + 2'h1;
    end else if (depth != 3'h0 && !i_hold) begin
      o_reti <= 1'b1;
      depth <= depth - 3'h1;
    end
  end
endmodule : tmrp_cpu_model
